// File: design/cfs_supervisor.sv
// charger fault supervisor: gate control, battery detection, fault handling, register slave
//
// Overview of operation
// - peak switch overcurrent cuts high side until next cycle
// - charge current above 160% blocks high side
// - high side resumes itself once overcurrent clears
// - sense below 5 mV keeps low side off
// - in DCM refresh bootstrap below 4 V
// - detection runs at power-up and on recharge fall
// - sink 8 mA; low within 1 s starts 125 mA
// - rise above recharge within 500 ms means no battery
// - either window expiring means battery present, charge
// - short below 2 V: off 1 ms, precharge restart
// - during short the low side stays undriven
// - high side inhibited at 102% regulation voltage
// - overvoltage over 30 ms disables charging
// - thermistor outside T1..T5 suspends switching
// - T1..T2 zone: 2.1 V target, half current
// - T2..T3 zone: 2.05 V target
// - T4..T5 zone: 2.025 V target
// - switch short latches off until adapter removal
// - thermal shutdown above 150, release below 130
// - timer fault clears when battery falls below recharge
// - reset or low current setting clears timer fault
// - fault current while below; above removes it, case one
// - status blinks on faults except battery short, on while charging
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "cfs_regs.svh"
module cfs_supervisor
   import cfs_pkg::*;
#(
   parameter int DISCH_CYC  = `CFS_T_DISCH_MS * `CFS_CLK_KHZ,
   parameter int DETCHG_CYC = `CFS_T_DETCHG_MS * `CFS_CLK_KHZ,
   parameter int SHORT_CYC  = `CFS_T_SHORT_MS * `CFS_CLK_KHZ,
   parameter int OVP_CYC    = `CFS_T_OVP_MS * `CFS_CLK_KHZ,
   parameter int BLINK_CYC  = `CFS_T_BLINK_MS * `CFS_CLK_KHZ
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [`CFS_AW-1:0] awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [`CFS_DW-1:0] wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   input  wire logic [`CFS_AW-1:0] araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [`CFS_DW-1:0]      rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   input  wire logic               cycle_start,
   input  wire logic               timer_fault,
   input  wire logic               peak_oc,
   input  wire logic               chg_oc160,
   input  wire logic               sense_below_5mv,
   input  wire logic               boot_below_4v,
   input  wire logic               dcm_mode,
   input  wire logic               bat_below_recharge,
   input  wire logic               bat_below_low_battery_threshold,
   input  wire logic               battery_sense_node_below_2v,
   input  wire logic               bat_ovp102,
   input  wire logic               switch_short,
   input  wire logic               tj_above_150,
   input  wire logic               tj_above_130,
   input  wire logic               charge_current_setting_input_below_40mv,
   input  wire logic               adapter_present,
   input  wire logic               input_ovp,
   input  wire logic [4:0]         ts_past_thr,
   output logic                    hs_gate_en,
   output logic                    ls_gate_en,
   output logic                    det_sink_en,
   output logic                    det_low_chg,
   output logic                    precharge_lvl,
   output logic                    fault_cur_en,
   output logic                    half_current,
   output cfs_fb_e                 fb_target,
   output logic                    adapter_side_switch,
   output logic                    stat_sink_on
);
   // ****************************************
   // comparator synchronisers
   // ****************************************
   localparam int SW = 20;
   logic [SW-1:0] sy1_r, sy2_r;
   logic pk_s, oc_s, snz_s, boot_s, dcm_s, rech_s, low_battery_threshold_s, bshort_s, ovp_s;
   logic swsh_s, tj150_s, tj130_s, charge_current_setting_input_s, adp_s, inovp_s;
   logic [4:0] ts_s;

   // two flops before any use
   always_ff @(posedge aclk) begin
      sy1_r <= {peak_oc, chg_oc160, sense_below_5mv, boot_below_4v, dcm_mode, bat_below_recharge,
                bat_below_low_battery_threshold, battery_sense_node_below_2v, bat_ovp102, switch_short,
                tj_above_150, tj_above_130, charge_current_setting_input_below_40mv, adapter_present, input_ovp, ts_past_thr};
      sy2_r <= sy1_r;
   end
   assign {pk_s, oc_s, snz_s, boot_s, dcm_s, rech_s, low_battery_threshold_s, bshort_s, ovp_s, swsh_s,
           tj150_s, tj130_s, charge_current_setting_input_s, adp_s, inovp_s, ts_s} = sy2_r;

   // ****************************************
   // register slave
   // ****************************************
   logic                 awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic                 aw_held_r, w_held_r, ctrl_en_r;
   logic [1:0]           bresp_r, rresp_r;
   logic [`CFS_AW-1:0]   awaddr_r;
   logic [`CFS_DW-1:0]   wdata_r, rdata_r;
   logic [3:0]           wstrb_r;
   logic                 aw_take, w_take, ar_take, wr_go, aw_nxt, w_nxt, rv_nxt;
   logic                 wr_ctrl, wr_hit, rd_ctrl, rd_stat;
   logic [`CFS_STAT_W-1:0] stat_word;

   // handshake and decode
   assign aw_take = awvalid && awready_r;
   assign w_take  = wvalid && wready_r;
   assign ar_take = arvalid && arready_r;
   assign wr_go   = aw_held_r && w_held_r && !bvalid_r;
   assign aw_nxt  = (aw_held_r && !wr_go) || aw_take;
   assign w_nxt   = (w_held_r && !wr_go) || w_take;
   assign rv_nxt  = (rvalid_r && !rready) || ar_take;
   assign wr_ctrl = awaddr_r == `CFS_CTRL_OFS;
   assign wr_hit  = wr_ctrl || awaddr_r == `CFS_STAT_OFS;
   assign rd_ctrl = araddr == `CFS_CTRL_OFS;
   assign rd_stat = araddr == `CFS_STAT_OFS;

   // write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {awready_r, wready_r, aw_held_r, w_held_r, bvalid_r} <= '0;
         bresp_r <= `CFS_RESP_OKAY;
         ctrl_en_r <= `CFS_CTRL_RST;
      end else begin
         aw_held_r <= aw_nxt;
         w_held_r  <= w_nxt;
         awready_r <= !aw_nxt;
         wready_r  <= !w_nxt;
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `CFS_RESP_OKAY : `CFS_RESP_SLVERR;
            if (wr_ctrl && wstrb_r[0]) ctrl_en_r <= wdata_r[`CFS_CTRL_EN_BIT];
         end else if (bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // captured write payload
   always_ff @(posedge aclk) begin
      if (aw_take) awaddr_r <= awaddr;
      if (w_take) begin
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {arready_r, rvalid_r} <= '0;
         rresp_r <= `CFS_RESP_OKAY;
         rdata_r <= '0;
      end else begin
         rvalid_r  <= rv_nxt;
         arready_r <= !rv_nxt;
         if (ar_take) begin
            rresp_r <= (rd_ctrl || rd_stat) ? `CFS_RESP_OKAY : `CFS_RESP_SLVERR;
            rdata_r <= rd_stat ? {{(`CFS_DW-`CFS_STAT_W){1'b0}}, stat_word} :
                       {{(`CFS_DW-1){1'b0}}, rd_ctrl && ctrl_en_r};
         end
      end
   end

   // ****************************************
   // fault flags and zone
   // ****************************************
   cfs_state_e st_r, st_nxt;
   cfs_zone_e  zone;
   logic latch_r, thermal_shutdown_threshold_r, nobat_r, above_seen_r, rech_prev_r, prechg_r;
   logic [`CFS_CNT_W-1:0] cnt_r, ovp_cnt_r, blink_cnt_r;
   logic blink_r, ts_ok, charging, conv_run, cnt_disch, cnt_det, cnt_short, ovp_trip;
   logic ls_block_r, hs_block_r, hs_nxt, ls_nxt, refresh, stat_nxt, blink_cond;

   // thermistor zone
   assign zone = !ts_s[0] ? ZN_COLD : !ts_s[1] ? ZN_T1T2 : !ts_s[2] ? ZN_T2T3 :
                 !ts_s[3] ? ZN_T3T4 : !ts_s[4] ? ZN_T4T5 : ZN_HOT;
   assign ts_ok = zone != ZN_COLD && zone != ZN_HOT;

   // latch-off and thermal shutdown with hysteresis
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_r <= 1'b0;
         thermal_shutdown_threshold_r <= 1'b0;
      end else begin
         if (swsh_s) latch_r <= 1'b1;
         else if (!adp_s) latch_r <= 1'b0;
         if (tj150_s) thermal_shutdown_threshold_r <= 1'b1;
         else if (!tj130_s) thermal_shutdown_threshold_r <= 1'b0;
      end
   end

   // ****************************************
   // detection and fault sequence
   // ****************************************
   assign cnt_disch = cnt_r == `CFS_CNT_W'(DISCH_CYC - 1);
   assign cnt_det   = cnt_r == `CFS_CNT_W'(DETCHG_CYC - 1);
   assign cnt_short = cnt_r == `CFS_CNT_W'(SHORT_CYC - 1);
   assign ovp_trip  = ovp_cnt_r == `CFS_CNT_W'(OVP_CYC);

   // next state
   always_comb begin
      st_nxt = st_r;
      if (!ctrl_en_r || charge_current_setting_input_s) begin
         st_nxt = ST_OFF;
      end else begin
         case (st_r)
            ST_OFF:    st_nxt = ST_DISCH;
            ST_DISCH: begin
               if (low_battery_threshold_s) st_nxt = ST_DETCHG;
               else if (cnt_disch) st_nxt = ST_CHARGE;
            end
            ST_DETCHG: begin
               if (!rech_s) st_nxt = ST_DISCH;
               else if (cnt_det) st_nxt = ST_CHARGE;
            end
            ST_CHARGE: begin
               if (timer_fault) st_nxt = ST_TFAULT;
               else if (ovp_trip) st_nxt = ST_OVPOFF;
               else if (bshort_s) st_nxt = ST_SHORT;
               else if (rech_s && !rech_prev_r) st_nxt = ST_DISCH;
            end
            ST_SHORT:  if (cnt_short) st_nxt = ST_CHARGE;
            ST_TFAULT: if (above_seen_r && rech_s) st_nxt = ST_DISCH;
            ST_OVPOFF: st_nxt = ST_OVPOFF;
            default:   st_nxt = ST_OFF;
         endcase
      end
   end

   // state, window counter and sequence flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_OFF;
         cnt_r <= '0;
         {nobat_r, above_seen_r, rech_prev_r, prechg_r} <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= (st_nxt != st_r) ? '0 : cnt_r + 1'b1;
         rech_prev_r <= rech_s;
         if (st_r == ST_DETCHG && st_nxt == ST_DISCH) nobat_r <= 1'b1;
         else if (st_nxt == ST_CHARGE) nobat_r <= 1'b0;
         above_seen_r <= st_r == ST_TFAULT && (above_seen_r || !rech_s);
         if (st_r == ST_SHORT && st_nxt == ST_CHARGE) prechg_r <= 1'b1;
         else if (st_nxt != ST_CHARGE) prechg_r <= 1'b0;
      end
   end

   // continuous overvoltage time
   always_ff @(posedge aclk) begin
      if (!aresetn || !ovp_s || st_r != ST_CHARGE) ovp_cnt_r <= '0;
      else if (!ovp_trip) ovp_cnt_r <= ovp_cnt_r + 1'b1;
   end

   // ****************************************
   // switch gating
   // ****************************************
   assign charging = st_r == ST_CHARGE || st_r == ST_DETCHG;
   assign conv_run = charging && ts_ok && !thermal_shutdown_threshold_r && !latch_r && adp_s;
   assign refresh  = dcm_s && boot_s;
   assign hs_nxt   = conv_run && !hs_block_r && !pk_s && !oc_s && !ovp_s;
   assign ls_nxt   = conv_run && !bshort_s && (!(ls_block_r || snz_s) || refresh);

   // per-cycle blocks; a new event beats the cycle restart
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_block_r <= 1'b0;
         ls_block_r <= 1'b0;
      end else begin
         hs_block_r <= pk_s || (hs_block_r && !cycle_start);
         ls_block_r <= (snz_s && charging) || (ls_block_r && !cycle_start);
      end
   end

   // ****************************************
   // status blink and outputs
   // ****************************************
   assign blink_cond = latch_r || inovp_s || ovp_s || nobat_r || st_r == ST_OVPOFF ||
                       st_r == ST_TFAULT || (charging && (!ts_ok || thermal_shutdown_threshold_r));
   assign stat_nxt   = blink_cond ? blink_r : charging;

   // blink phase generator
   always_ff @(posedge aclk) begin
      if (!aresetn || blink_cnt_r == `CFS_CNT_W'(BLINK_CYC - 1)) blink_cnt_r <= '0;
      else blink_cnt_r <= blink_cnt_r + 1'b1;
      if (!aresetn) blink_r <= 1'b0;
      else if (blink_cnt_r == `CFS_CNT_W'(BLINK_CYC - 1)) blink_r <= !blink_r;
   end

   // registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {hs_gate_en, ls_gate_en, det_sink_en, det_low_chg, precharge_lvl} <= '0;
         {fault_cur_en, half_current, adapter_side_switch, stat_sink_on} <= '0;
         fb_target <= FB_2V050;
      end else begin
         hs_gate_en    <= hs_nxt;
         ls_gate_en    <= ls_nxt;
         det_sink_en   <= st_nxt == ST_DISCH;
         det_low_chg   <= st_nxt == ST_DETCHG;
         precharge_lvl <= prechg_r;
         fault_cur_en  <= st_r == ST_TFAULT && rech_s && !above_seen_r;
         half_current  <= zone == ZN_T1T2;
         fb_target     <= zone == ZN_T1T2 ? FB_2V100 :
                          zone == ZN_T4T5 ? FB_2V025 : FB_2V050;
         adapter_side_switch <= adp_s;
         stat_sink_on  <= stat_nxt;
      end
   end

   assign stat_word = {1'b0, stat_sink_on, inovp_s, ovp_s, ls_gate_en, hs_gate_en, nobat_r,
                       thermal_shutdown_threshold_r, latch_r, zone, st_r, ctrl_en_r};
   assign {awready, wready, bvalid, bresp} = {awready_r, wready_r, bvalid_r, bresp_r};
   assign {arready, rvalid, rresp, rdata}  = {arready_r, rvalid_r, rresp_r, rdata_r};

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_short_hit;
      st_r == ST_CHARGE && ctrl_en_r && !charge_current_setting_input_s && !timer_fault && !ovp_trip && bshort_s;
   endsequence
   sequence seq_low_hit;
      st_r == ST_DISCH && ctrl_en_r && !charge_current_setting_input_s && low_battery_threshold_s;
   endsequence

   peak_cut_a:   assert property (hs_block_r && !cycle_start |=> !hs_gate_en)
      else $error("high side on while peak block held");
   oc160_cut_a:  assert property (oc_s |=> !hs_gate_en)
      else $error("high side on above 160 percent");
   oc_resume_a:  assert property (conv_run && !hs_block_r && !pk_s && !oc_s && !ovp_s |=> hs_gate_en)
      else $error("high side did not resume");
   ls_under_a:   assert property (ls_block_r && !refresh |=> !ls_gate_en)
      else $error("low side on after undercurrent");
   boot_fresh_a: assert property (conv_run && refresh && !bshort_s |=> ls_gate_en)
      else $error("no bootstrap refresh");
   det_low_a:    assert property (seq_low_hit |=> st_r == ST_DETCHG ##0 !det_sink_en && det_low_chg)
      else $error("detection did not switch to low charge");
   short_off_a:  assert property (seq_short_hit |=> st_r == ST_SHORT ##1 !hs_gate_en && !ls_gate_en)
      else $error("battery short did not stop switching");
   short_ns_a:   assert property (bshort_s |=> !ls_gate_en)
      else $error("low side driven during short");
   ovp_cut_a:    assert property (ovp_s |=> !hs_gate_en)
      else $error("high side on in overvoltage");
   thermal_shutdown_threshold_hold_a: assert property (thermal_shutdown_threshold_r && tj130_s |=> thermal_shutdown_threshold_r ##0 !hs_gate_en)
      else $error("thermal shutdown released early");
   latch_hold_a: assert property (latch_r && adp_s |=> latch_r && adapter_side_switch)
      else $error("latch cleared with adapter present");
endmodule

// File: common/cfs_regs.svh
// register map, field layout, reset values and timing figures of the charger supervisor
`ifndef CFS_REGS_SVH
`define CFS_REGS_SVH
// ****************************************
// bus layout
// ****************************************
`define CFS_AW          8
`define CFS_DW          32
`define CFS_CTRL_OFS    8'h00
`define CFS_STAT_OFS    8'h04
`define CFS_CTRL_EN_BIT 0
`define CFS_CTRL_RST    1'b1
`define CFS_STAT_W      16
`define CFS_RESP_OKAY   2'b00
`define CFS_RESP_SLVERR 2'b10
// ****************************************
// timing figures
// ****************************************
`define CFS_CLK_KHZ     250000
`define CFS_T_DISCH_MS  1000
`define CFS_T_DETCHG_MS 500
`define CFS_T_SHORT_MS  1
`define CFS_T_OVP_MS    30
`define CFS_T_BLINK_MS  500
`define CFS_CNT_W       28
`endif

// File: common/cfs_pkg.sv
// types shared by the charger supervisor
package cfs_pkg;
   // supervisor sequence states
   typedef enum logic [2:0] {
      ST_OFF, ST_DISCH, ST_DETCHG, ST_CHARGE, ST_SHORT, ST_TFAULT, ST_OVPOFF
   } cfs_state_e;
   // thermistor temperature zones, coldest first
   typedef enum logic [2:0] {
      ZN_COLD, ZN_T1T2, ZN_T2T3, ZN_T3T4, ZN_T4T5, ZN_HOT
   } cfs_zone_e;
   // feedback regulation targets
   typedef enum logic [1:0] {
      FB_2V100, FB_2V050, FB_2V025
   } cfs_fb_e;
endpackage

// File: bench/cfs_battery_model.sv
// behavioural battery pack model driving the detection comparators
`timescale 1ns/10ps
module cfs_battery_model (
   input  wire logic aclk,
   input  wire logic present,
   input  wire logic drop,
   input  wire logic sink_on,
   input  wire logic low_chg_on,
   output logic      below_low,
   output logic      below_recharge
);
   int level = 8;
   // a real pack holds its voltage; an empty socket follows sink and charge
   always @(posedge aclk) begin
      if (present) level <= drop ? 5 : 8;
      else if (sink_on && level > 0) level <= level - 1;
      else if (low_chg_on && level < 10) level <= level + 1;
   end
   // low threshold under the recharge threshold
   assign below_low      = (level < 3);
   assign below_recharge = (level < 7);
endmodule

// File: bench/charger_fault_supervisor_test.sv
// self-checking bench for the charger fault supervisor
`timescale 1ns/10ps
module charger_fault_supervisor_test;
   import cfs_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [4:0] ts = 5'h07;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid;
   logic cyc = 0, tmf = 0, poc = 0, oc160 = 0, s5 = 0, b4 = 0, dcm = 0, b2v = 0, ovp = 0, ssh = 0;
   logic t150 = 0, t130 = 0, charge_current_setting_input = 0, adp = 1, iovp = 0, present = 0, drop = 0, blow, brch;
   logic hs, ls, sink, lowc, prel, fcur, half, adsw, stat, saw0, saw1;
   cfs_fb_e fb;
   int failures = 0, checks = 0;
   logic [31:0] d;
   logic [1:0] r;
   initial forever #2 aclk = ~aclk;
   cfs_battery_model i_cfs_battery_model (.aclk(aclk), .present(present), .drop(drop), .sink_on(sink),
      .low_chg_on(lowc), .below_low(blow), .below_recharge(brch));
   cfs_supervisor #(.DISCH_CYC(40), .DETCHG_CYC(20), .SHORT_CYC(8), .OVP_CYC(10), .BLINK_CYC(4)) i_cfs_supervisor (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .cycle_start(cyc), .timer_fault(tmf), .peak_oc(poc), .chg_oc160(oc160),
      .sense_below_5mv(s5), .boot_below_4v(b4), .dcm_mode(dcm), .bat_below_recharge(brch),
      .bat_below_low_battery_threshold(blow), .battery_sense_node_below_2v(b2v), .bat_ovp102(ovp),
      .switch_short(ssh), .tj_above_150(t150), .tj_above_130(t130), .charge_current_setting_input_below_40mv(charge_current_setting_input),
      .adapter_present(adp), .input_ovp(iovp), .ts_past_thr(ts), .hs_gate_en(hs), .ls_gate_en(ls),
      .det_sink_en(sink), .det_low_chg(lowc), .precharge_lvl(prel), .fault_cur_en(fcur),
      .half_current(half), .fb_target(fb), .adapter_side_switch(adsw), .stat_sink_on(stat));
   // ****************************************
   // checks and bus cycles
   // ****************************************
   task automatic final_report();
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk_lvl(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin failures++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      bit ad, wd;
      ad = 0; wd = 0;
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; end
         if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 0; end
      end
      bready <= 1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp; bready <= 0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      araddr <= a; arvalid <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0; rready <= 1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata; resp = rresp; rready <= 0;
   endtask
   // poll the status state field until it reaches s, then compare it
   task automatic wait_st(input int s);
      for (int k = 0; k < 150; k++) begin
         axr(8'h04, d, r);
         if (d[3:1] === s[2:0]) break;
      end
      chk_word({29'h0, d[3:1]}, s);
   endtask
   initial begin
      cy(40000);
      failures++;
      final_report();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(40));
      cy(2); aresetn <= 1; cy(4);
      axr(8'h00, d, r); chk_word(d, 32'h1);
      axr(8'h08, d, r); chk_word(d, 32'h0); chk_word({30'h0, r}, 32'h2);
      axw(8'h10, 32'h0, r); chk_word({30'h0, r}, 32'h2);
      axw(8'h04, $urandom, r); chk_word({30'h0, r}, 32'h0);
      wait_st(2); chk_lvl(lowc, 1); chk_lvl(sink, 0);
      wait_st(1); chk_lvl(sink, 1); chk_lvl(d[9], 1);
      present <= 1; wait_st(3); chk_lvl(hs, 1); chk_lvl(stat, 1);
      poc <= 1; cy(5); chk_lvl(hs, 0);
      poc <= 0; cy(5); chk_lvl(hs, 0);
      cyc <= 1; cy(1); cyc <= 0; cy(3); chk_lvl(hs, 1);
      oc160 <= 1; cy(5); chk_lvl(hs, 0);
      oc160 <= 0; cy(1); cyc <= 1; cy(1); cyc <= 0; cy(5); chk_lvl(hs, 1);
      dcm <= 1; s5 <= 1; cy(5); chk_lvl(ls, 0);
      b4 <= 1; cy(5); chk_lvl(ls, 1);
      b4 <= 0; s5 <= 0; dcm <= 0; cy(3); cyc <= 1; cy(1); cyc <= 0;
      for (int k = 0; k < 6; k++) begin
         ts <= 5'((1 << k) - 1); cy(6 + $urandom % 4);
         axr(8'h04, d, r); chk_word({29'h0, d[6:4]}, k);
         chk_lvl(hs, k != 0 && k != 5); chk_lvl(ls, k != 0 && k != 5);
         if (k == 1) begin chk_word(fb, 0); chk_lvl(half, 1); end
         if (k == 2) chk_word(fb, 1);
         if (k == 3) begin chk_word(fb, 1); chk_lvl(half, 0); end
         if (k == 4) chk_word(fb, 2);
      end
      ts <= 5'h07; cy(6);
      t150 <= 1; t130 <= 1; cy(5); chk_lvl(hs, 0);
      t150 <= 0; cy(5); chk_lvl(hs, 0);
      t130 <= 0; cy(5); chk_lvl(hs, 1);
      b2v <= 1; cy(5); chk_lvl(hs, 0); chk_lvl(ls, 0);
      axr(8'h04, d, r); chk_word({29'h0, d[3:1]}, 4);
      b2v <= 0; wait_st(3); chk_lvl(prel, 1);
      ssh <= 1; cy(5); ssh <= 0; saw0 = 0; saw1 = 0;
      repeat (24) begin cy(1); saw0 |= !stat; saw1 |= stat; end
      chk_lvl(saw0 & saw1, 1); chk_lvl(adsw, 1); chk_lvl(hs, 0);
      axr(8'h04, d, r); chk_lvl(d[7], 1);
      adp <= 0; cy(6); chk_lvl(adsw, 0); adp <= 1; cy(6);
      axr(8'h04, d, r); chk_lvl(d[7], 0);
      wait_st(3);
      ovp <= 1; cy(5); chk_lvl(hs, 0);
      cy(12); wait_st(6); ovp <= 0;
      axw(8'h00, 32'h0, r); chk_word({30'h0, r}, 32'h0);
      wait_st(0); cy(2); chk_lvl(stat, 0);
      axw(8'h00, 32'h1, r); wait_st(3);
      iovp <= 1; cy(5); axr(8'h04, d, r); chk_lvl(d[13], 1); iovp <= 0;
      wait_st(3); tmf <= 1; cy(1); tmf <= 0; wait_st(5); chk_lvl(fcur, 0);
      drop <= 1; wait_st(1); wait_st(3);
      tmf <= 1; cy(1); tmf <= 0; wait_st(5); cy(4); chk_lvl(fcur, 1);
      drop <= 0; cy(6); chk_lvl(fcur, 0);
      drop <= 1; wait_st(1); wait_st(3);
      tmf <= 1; cy(1); tmf <= 0; wait_st(5); charge_current_setting_input <= 1; wait_st(0);
      charge_current_setting_input <= 0; wait_st(3);
      final_report();
   end
endmodule
